// file: core/pio_pkg.sv
package pio_pkg;
  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [3:0] IDX_GEN_OUT = 4'h0;
  localparam logic [3:0] IDX_GEN_CFG = 4'h1;
  localparam logic [3:0] IDX_GEN_PIN = 4'h2;
  localparam logic [3:0] IDX_WK_OUT = 4'h3;
  localparam logic [3:0] IDX_WK_CFG = 4'h4;
  localparam logic [3:0] IDX_WK_PIN = 4'h5;
  localparam logic [3:0] IDX_ANA_PIN = 4'h6;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h7;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h8;
  localparam logic [3:0] IDX_WK_EDGE = 4'h9;
  localparam int ADDR_W = 6;
  // ==========================================================
  // Field positions of the general port
  localparam int GEN_ERR_BIT = 1;
  localparam int GEN_IDLE_BIT = 6;
  localparam int GEN_HALT_BIT = 7;
  localparam int GEN_ALTSK_BIT = 6;
  localparam int GEN_DLY_BIT = 7;
  // I/O pin mask: bits 0, 2, 3, 4, 5
  localparam logic [7:0] GEN_IO_MASK = 8'h3D;
  // Wake-up port pins in high nibble; low nibble reads ones
  localparam logic [3:0] WK_LOW_ONES = 4'hF;
  // ==========================================================
  // Status bits: 3..0 wake-up pins, 4 ext irq, 5 rc halt wake
  localparam int ST_EXT_BIT = 4;
  localparam int ST_RCW_BIT = 5;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ==========================================================
  // Startup delay after halt, in ns, and cycle count at 25 MHz
  localparam int CLK_NS = 40;
  localparam int STARTUP_NS = 1000;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {PM_RUN, PM_HALT, PM_IDLE, PM_WAKE} pio_pm_t;
endpackage

// file: core/pio_port_io_config.sv
`timescale 1ns/1ps
module pio_port_io_config #(
  parameter int STARTUP_CYCLES = pio_pkg::STARTUP_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic [pio_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Oscillator option: 1 crystal, 0 single-pin RC
  input wire logic oscCrystal,
  input wire logic oscillator_output,
  input wire logic supervisor_error_out,
  // General port pins
  input wire logic [7:0] genPinIn,
  output logic [7:0] genPinOut,
  output logic [7:0] genPinOe,
  output logic [7:0] genPullUp,
  // Wake-up port pins, bits 7..4
  input wire logic [3:0] wkPinIn,
  output logic [3:0] wkPinOut,
  output logic [3:0] wkPinOe,
  output logic [3:0] wkPullUp,
  // Analog port pins
  input wire logic [7:0] anaPinIn,
  // Alternate function taps
  output logic serialDataIn,
  output logic serial_shift_clock,
  output logic timer_io_pin,
  output logic timer_capture_pin,
  output logic external_interrupt_pin,
  output logic comparator_output,
  output logic current_source_output,
  output logic [4:0] comparatorChannels,
  output logic altShiftPhase,
  // Power modes and wake-up
  output logic haltMode,
  output logic idleMode,
  output logic halt_startup_delay,
  output logic multi_input_wakeup,
  output logic irq
);
  // ==========================================================
  // Registers and synchronisers
  logic [7:0] genOut, genCfg, wkOut, wkCfg, irqStat, irqMask, wkEdge;
  logic [7:0] genS1, genS2, anaS1, anaS2;
  logic [3:0] wkS1, wkS2, wkPrev;
  logic g7Prev, extPrev;
  logic [1:0] syncFill;
  pio_pkg::pio_pm_t pm;
  logic [15:0] dlyCnt;
  logic [7:0] next_rdata;
  logic [3:0] wkHit;
  logic extHit, rcWake, edgeOk;

  // Two-flop synchronisers on all pin inputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      genS1 <= 8'h00;
      genS2 <= 8'h00;
      wkS1 <= 4'h0;
      wkS2 <= 4'h0;
      anaS1 <= 8'h00;
      anaS2 <= 8'h00;
    end else begin
      genS1 <= genPinIn;
      genS2 <= genS1;
      wkS1 <= wkPinIn;
      wkS2 <= wkS1;
      anaS1 <= anaPinIn;
      anaS2 <= anaS1;
    end
  end

  // ==========================================================
  // Software registers, cleared on reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      genOut <= pio_pkg::RST_BYTE;
      genCfg <= pio_pkg::RST_BYTE;
      wkOut <= pio_pkg::RST_BYTE;
      wkCfg <= pio_pkg::RST_BYTE;
      irqMask <= pio_pkg::RST_BYTE;
      wkEdge <= pio_pkg::RST_BYTE;
    end else if (regWr) begin
      if (regAddr == {pio_pkg::IDX_GEN_OUT, 2'b00}) begin
        genOut <= regWdata & 8'h3F; // Bits 6,7 are strobes
      end else if (regAddr == {pio_pkg::IDX_GEN_CFG, 2'b00}) begin
        genCfg <= regWdata;
      end else if (regAddr == {pio_pkg::IDX_WK_OUT, 2'b00}) begin
        wkOut <= regWdata;
      end else if (regAddr == {pio_pkg::IDX_WK_CFG, 2'b00}) begin
        wkCfg <= regWdata;
      end else if (regAddr == {pio_pkg::IDX_IRQ_MASK, 2'b00}) begin
        irqMask <= regWdata;
      end else if (regAddr == {pio_pkg::IDX_WK_EDGE, 2'b00}) begin
        wkEdge <= regWdata;
      end
    end
  end

  // ==========================================================
  // Pin drive decode for general and wake-up ports
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      genPinOut <= 8'h00;
      genPinOe <= 8'h00;
      genPullUp <= 8'h00;
      wkPinOut <= 4'h0;
      wkPinOe <= 4'h0;
      wkPullUp <= 4'h0;
    end else begin
      // Configurable bits follow cfg/data decode
      genPinOut <= genOut & pio_pkg::GEN_IO_MASK;
      genPinOe <= genCfg & pio_pkg::GEN_IO_MASK;
      genPullUp <= ~genCfg & genOut & pio_pkg::GEN_IO_MASK;
      // Bit 1 is driven low only while the supervisor flags error
      genPinOut[pio_pkg::GEN_ERR_BIT] <= 1'b0;
      genPinOe[pio_pkg::GEN_ERR_BIT] <= supervisor_error_out;
      // Bit 7 drives the oscillator in crystal mode
      genPinOut[pio_pkg::GEN_HALT_BIT] <= oscillator_output;
      genPinOe[pio_pkg::GEN_HALT_BIT] <= oscCrystal;
      wkPinOut <= wkOut[7:4];
      wkPinOe <= wkCfg[7:4];
      wkPullUp <= ~wkCfg[7:4] & wkOut[7:4];
    end
  end

  // ==========================================================
  // Alternate function taps from synchronised pins, shift phase from genCfg, startup delay from genCfg in RC mode only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      serialDataIn <= 1'b0;
      serial_shift_clock <= 1'b0;
      timer_io_pin <= 1'b0;
      timer_capture_pin <= 1'b0;
      external_interrupt_pin <= 1'b0;
      comparator_output <= 1'b0;
      current_source_output <= 1'b0;
      comparatorChannels <= 5'h00;
      altShiftPhase <= 1'b0;
      halt_startup_delay <= 1'b0;
    end else begin
      serialDataIn <= genS2[6];
      serial_shift_clock <= genS2[5];
      timer_io_pin <= genS2[3];
      timer_capture_pin <= genS2[2];
      external_interrupt_pin <= genS2[0];
      comparator_output <= anaS2[7];
      current_source_output <= anaS2[1];
      comparatorChannels <= anaS2[6:2];
      altShiftPhase <= genCfg[pio_pkg::GEN_ALTSK_BIT];
      halt_startup_delay <= ~oscCrystal & genCfg[pio_pkg::GEN_DLY_BIT];
    end
  end

  // ==========================================================
  // Wake and interrupt event detection
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wkPrev <= 4'h0;
      g7Prev <= 1'b0;
      extPrev <= 1'b0;
      syncFill <= 2'b00;
    end else begin
      // History holds real pin levels only after three cycles
      if (syncFill != 2'b11) begin
        syncFill <= syncFill + 2'b01;
      end
      wkPrev <= wkS2;
      g7Prev <= genS2[7];
      extPrev <= genS2[0];
    end
  end

  // Edge select: wkEdge bit 1 means falling edge
  // Edges are masked after reset so a high idle pin is no false event
  always_comb begin
    edgeOk = (syncFill == 2'b11);
    for (int i = 0; i < 4; i++) begin
      wkHit[i] = edgeOk & (wkEdge[i + 4] ? (wkPrev[i] & ~wkS2[i])
                                         : (~wkPrev[i] & wkS2[i]));
    end
    extHit = edgeOk & extPrev & ~genS2[0];
    rcWake = edgeOk & ~oscCrystal & ~g7Prev & genS2[7];
  end

  // Sticky status; a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqStat <= 8'h00;
    end else begin
      irqStat <= ((regRd && regAddr == {pio_pkg::IDX_IRQ_STAT, 2'b00})
                  ? 8'h00 : irqStat)
                 | {2'b00, rcWake, extHit, wkHit};
    end
  end

  // Interrupt and wake-up outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
      multi_input_wakeup <= 1'b0;
    end else begin
      irq <= |(irqStat & irqMask);
      multi_input_wakeup <= |wkHit;
    end
  end

  // ==========================================================
  // Power mode control: HALT, IDLE, optional startup delay
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pm <= pio_pkg::PM_RUN;
      dlyCnt <= 16'h0000;
    end else begin
      case (pm)
        pio_pkg::PM_RUN: begin
          if (regWr && regAddr == {pio_pkg::IDX_GEN_OUT, 2'b00}) begin
            if (regWdata[pio_pkg::GEN_HALT_BIT]) begin
              pm <= pio_pkg::PM_HALT;
            end else if (regWdata[pio_pkg::GEN_IDLE_BIT]) begin
              pm <= pio_pkg::PM_IDLE;
            end
          end
        end
        pio_pkg::PM_HALT: begin
          if (rcWake || (|wkHit) || extHit) begin
            if (halt_startup_delay) begin
              pm <= pio_pkg::PM_WAKE;
              dlyCnt <= 16'(STARTUP_CYCLES - 1);
            end else begin
              pm <= pio_pkg::PM_RUN;
            end
          end
        end
        pio_pkg::PM_IDLE: begin
          if ((|wkHit) || extHit || rcWake) begin
            pm <= pio_pkg::PM_RUN;
          end
        end
        pio_pkg::PM_WAKE: begin
          if (dlyCnt == 16'h0000) begin
            pm <= pio_pkg::PM_RUN;
          end else begin
            dlyCnt <= dlyCnt - 16'h0001;
          end
        end
        default: pm <= pio_pkg::PM_RUN;
      endcase
    end
  end

  // Mode outputs registered
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      haltMode <= 1'b0;
      idleMode <= 1'b0;
    end else begin
      haltMode <= (pm == pio_pkg::PM_HALT) || (pm == pio_pkg::PM_WAKE);
      idleMode <= (pm == pio_pkg::PM_IDLE);
    end
  end

  // ==========================================================
  // Read decode, data one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (regAddr == {pio_pkg::IDX_GEN_OUT, 2'b00}) begin
      next_rdata = genOut & 8'h3F;
    end else if (regAddr == {pio_pkg::IDX_GEN_CFG, 2'b00}) begin
      next_rdata = genCfg;
    end else if (regAddr == {pio_pkg::IDX_GEN_PIN, 2'b00}) begin
      next_rdata = genS2;
    end else if (regAddr == {pio_pkg::IDX_WK_OUT, 2'b00}) begin
      next_rdata = wkOut;
    end else if (regAddr == {pio_pkg::IDX_WK_CFG, 2'b00}) begin
      next_rdata = wkCfg;
    end else if (regAddr == {pio_pkg::IDX_WK_PIN, 2'b00}) begin
      next_rdata = {wkS2, pio_pkg::WK_LOW_ONES};
    end else if (regAddr == {pio_pkg::IDX_ANA_PIN, 2'b00}) begin
      next_rdata = anaS2;
    end else if (regAddr == {pio_pkg::IDX_IRQ_STAT, 2'b00}) begin
      next_rdata = irqStat;
    end else if (regAddr == {pio_pkg::IDX_IRQ_MASK, 2'b00}) begin
      next_rdata = irqMask;
    end else if (regAddr == {pio_pkg::IDX_WK_EDGE, 2'b00}) begin
      next_rdata = wkEdge;
    end
  end

  // Read data register, zero outside the answer cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= regRd ? next_rdata : 8'h00;
    end
  end

  // ==========================================================
  // Checks
  sequence s_haltWrite;
    regWr && regAddr == {pio_pkg::IDX_GEN_OUT, 2'b00}
      && regWdata[7] && pm == pio_pkg::PM_RUN;
  endsequence
  property p_halt;
    @(posedge ref_clk) disable iff (!rstn) s_haltWrite |=> ##1 haltMode;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not entered");
  property p_idle;
    @(posedge ref_clk) disable iff (!rstn)
      (regWr && regAddr == {pio_pkg::IDX_GEN_OUT, 2'b00}
       && regWdata[7:6] == 2'b01 && pm == pio_pkg::PM_RUN)
      |=> ##1 idleMode;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not entered");
  property p_wkOnes;
    @(posedge ref_clk) disable iff (!rstn)
      (regRd && regAddr == {pio_pkg::IDX_WK_PIN, 2'b00})
      |=> regRdata[3:0] == 4'hF;
  endproperty
  a_wkOnes: assert property (p_wkOnes)
    else $error("low nibble not ones");
  property p_genZero;
    @(posedge ref_clk) disable iff (!rstn)
      (regRd && regAddr == {pio_pkg::IDX_GEN_OUT, 2'b00})
      |=> regRdata[7:6] == 2'b00;
  endproperty
  a_genZero: assert property (p_genZero)
    else $error("bits 6,7 nonzero");
  property p_readBack;
    @(posedge ref_clk) disable iff (!rstn)
      (regWr && regAddr == {pio_pkg::IDX_WK_CFG, 2'b00})
      ##1 (regRd && regAddr == {pio_pkg::IDX_WK_CFG, 2'b00})
      |=> regRdata == $past(regWdata, 2);
  endproperty
  a_readBack: assert property (p_readBack)
    else $error("readback wrong");
  property p_drive;
    @(posedge ref_clk) disable iff (!rstn)
      genPinOe[0] == $past(genCfg[0]) && genPinOut[0] == $past(genOut[0]);
  endproperty
  a_drive: assert property (p_drive) else $error("pin decode wrong");
  property p_errPin;
    @(posedge ref_clk) disable iff (!rstn)
      genPinOut[1] == 1'b0 && genPinOe[1] == $past(supervisor_error_out);
  endproperty
  a_errPin: assert property (p_errPin) else $error("error pin wrong");
  property p_rcWake;
    @(posedge ref_clk) disable iff (!rstn)
      (pm == pio_pkg::PM_HALT && rcWake && !halt_startup_delay)
      |=> pm == pio_pkg::PM_RUN;
  endproperty
  a_rcWake: assert property (p_rcWake) else $error("rc wake missed");
  property p_delay;
    @(posedge ref_clk) disable iff (!rstn)
      (pm == pio_pkg::PM_HALT && rcWake && halt_startup_delay)
      |=> pm == pio_pkg::PM_WAKE;
  endproperty
  a_delay: assert property (p_delay) else $error("no startup delay");
endmodule

// file: testbench/pio_pin_model.sv
`timescale 1ns/1ps
// ==========================================================
// Outside world on the general, wake-up and analog pins
module pio_pin_model (
  // Clock
  input wire logic ref_clk,
  // Device drive
  input wire logic [7:0] genPinOut,
  input wire logic [7:0] genPinOe,
  input wire logic [7:0] genPullUp,
  input wire logic [3:0] wkPinOut,
  input wire logic [3:0] wkPinOe,
  input wire logic [3:0] wkPullUp,
  // Outside drive
  input wire logic [7:0] extGenEn,
  input wire logic [7:0] extGenVal,
  input wire logic [3:0] extWkEn,
  input wire logic [3:0] extWkVal,
  input wire logic [7:0] extAna,
  // Levels seen by the device
  output logic [7:0] genPinIn,
  output logic [3:0] wkPinIn,
  output logic [7:0] anaPinIn
);
  logic flt = 1'b0;
  // Floating pins wander every cycle
  always_ff @(posedge ref_clk) begin
    flt <= ~flt;
  end
  // Device drive wins, then outside drive, then pull-up
  assign genPinIn = (genPinOe & genPinOut)
    | (~genPinOe & extGenEn & extGenVal)
    | (~genPinOe & ~extGenEn & (genPullUp | {8{flt}}));
  assign wkPinIn = (wkPinOe & wkPinOut)
    | (~wkPinOe & extWkEn & extWkVal)
    | (~wkPinOe & ~extWkEn & (wkPullUp | {4{flt}}));
  // Analog pins are only ever driven from outside
  assign anaPinIn = extAna;
endmodule

// file: testbench/pio_port_io_config_bench.sv
`timescale 1ns/1ps
module pio_port_io_config_bench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] regAddr = 6'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic oscCrystal = 1'b0;
  logic oscillator_output = 1'b0;
  logic supervisor_error_out = 1'b0;
  logic [7:0] extGenEn = 8'hFF;
  logic [7:0] extGenVal = 8'h00;
  logic [3:0] extWkEn = 4'hF;
  logic [3:0] extWkVal = 4'h0;
  logic [7:0] extAna = 8'h00;
  logic [7:0] genPinIn, genPinOut, genPinOe, genPullUp, anaPinIn, regRdata;
  logic [3:0] wkPinIn, wkPinOut, wkPinOe, wkPullUp;
  logic [4:0] comparatorChannels;
  logic serialDataIn, serial_shift_clock, timer_io_pin, timer_capture_pin;
  logic external_interrupt_pin, comparator_output, current_source_output;
  logic altShiftPhase, haltMode, idleMode, halt_startup_delay;
  logic multi_input_wakeup, irq;
  logic [7:0] rdv, r, lvl;
  logic [3:0] wlv;
  int numErrors = 0;
  int checks = 0;
  int wakeCnt = 0;
  int seed = 32'h9c0d;
  int mdl [16];
  int i, m, n;

  // Clock
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // Count wake-up pulses, each one cycle long
  always @(posedge ref_clk) begin
    if (multi_input_wakeup === 1'b1) wakeCnt <= wakeCnt + 1;
  end

  pio_port_io_config #(.STARTUP_CYCLES(2)) pio_port_io_config_i (
    .ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .oscCrystal(oscCrystal),
    .oscillator_output(oscillator_output),
    .supervisor_error_out(supervisor_error_out), .genPinIn(genPinIn),
    .genPinOut(genPinOut), .genPinOe(genPinOe), .genPullUp(genPullUp),
    .wkPinIn(wkPinIn), .wkPinOut(wkPinOut), .wkPinOe(wkPinOe),
    .wkPullUp(wkPullUp), .anaPinIn(anaPinIn), .serialDataIn(serialDataIn),
    .serial_shift_clock(serial_shift_clock), .timer_io_pin(timer_io_pin),
    .timer_capture_pin(timer_capture_pin),
    .external_interrupt_pin(external_interrupt_pin),
    .comparator_output(comparator_output),
    .current_source_output(current_source_output),
    .comparatorChannels(comparatorChannels), .altShiftPhase(altShiftPhase),
    .haltMode(haltMode), .idleMode(idleMode),
    .halt_startup_delay(halt_startup_delay),
    .multi_input_wakeup(multi_input_wakeup), .irq(irq));

  pio_pin_model pio_pin_model_i (
    .ref_clk(ref_clk), .genPinOut(genPinOut), .genPinOe(genPinOe),
    .genPullUp(genPullUp), .wkPinOut(wkPinOut), .wkPinOe(wkPinOe),
    .wkPullUp(wkPullUp), .extGenEn(extGenEn), .extGenVal(extGenVal),
    .extWkEn(extWkEn), .extWkVal(extWkVal), .extAna(extAna),
    .genPinIn(genPinIn), .wkPinIn(wkPinIn), .anaPinIn(anaPinIn));

  // ==========================================================
  // Bus cycles and comparison
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      numErrors++;
    end
  endtask
  task automatic wr(input logic [3:0] x, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= {x, 2'b00};
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    mdl[x] = d;
  endtask
  task automatic rd(input logic [3:0] x, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= {x, 2'b00};
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic waitMode(input bit h, input logic v);
    for (n = 0; n < 40 && (h ? haltMode : idleMode) !== v; n++)
      @(posedge ref_clk);
    chk(h ? "halt" : "idle", {7'h0, v}, {7'h0, h ? haltMode : idleMode});
  endtask
  task automatic testDone;
    $display("checks %0d mismatches %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    $display("mismatch timeout expected end seen hang");
    numErrors++;
    testDone;
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (mdl[k]) mdl[k] = 0;
    for (i = 0; i < 5; i++) begin
      rd(i[3:0], rdv);
      if (i != 2) chk("reset reg", 8'h00, rdv);
    end
    chk("reset oe", 8'h00, genPinOe);
    rd(4'hF, rdv);
    chk("unmapped", 8'h00, rdv);
    $display("test reset done");
    // Four pin set-ups on both ports
    for (m = 0; m < 4; m++) begin
      r = $random(seed);
      extGenVal <= r;
      extWkVal <= r[7:4];
      extGenEn <= (m == 1) ? 8'hC2 : 8'hFF;
      extWkEn <= (m == 1) ? 4'h0 : 4'hF;
      wr(pio_pkg::IDX_GEN_CFG, m[1] ? pio_pkg::GEN_IO_MASK : 8'h00);
      wr(pio_pkg::IDX_GEN_OUT, m[0] ? pio_pkg::GEN_IO_MASK : 8'h00);
      wr(pio_pkg::IDX_WK_CFG, {{4{m[1]}}, r[3:0]});
      regRd <= 1'b1; // Read straight after the write
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 rdv = regRdata;
      chk("wk cfg b2b", mdl[4][7:0], rdv);
      wr(pio_pkg::IDX_WK_OUT, {{4{m[0]}}, r[7:4]});
      repeat (4) @(posedge ref_clk);
      lvl = (m[1] ? {8{m[0]}} : (m == 1 ? 8'hFF : r)) & 8'h3D | r & 8'h40;
      wlv = m[1] ? {4{m[0]}} : (m == 1 ? 4'hF : r[7:4]);
      chk("gen oe", {8{m[1]}} & 8'h3D, genPinOe & 8'h3D);
      chk("gen pull", {8{m == 1}} & 8'h3D, genPullUp & 8'h3D);
      chk("wk oe", {4'h0, {4{m[1]}}}, {4'h0, wkPinOe});
      chk("gen out", {8{m[0]}} & 8'h3D, genPinOut & 8'h3D);
      chk("wk pull", {4'h0, {4{m == 1}}}, {4'h0, wkPullUp});
      chk("wk drive", {4'h0, {4{m[0]}}}, {4'h0, wkPinOut});
      rd(pio_pkg::IDX_GEN_PIN, rdv);
      chk("gen pin", lvl, rdv & 8'h7D);
      rd(pio_pkg::IDX_WK_PIN, rdv);
      chk("wk pin", {wlv, 4'hF}, rdv);
      rd(pio_pkg::IDX_WK_CFG, rdv);
      chk("wk cfg", mdl[4][7:0], rdv);
      rd(pio_pkg::IDX_WK_OUT, rdv);
      chk("wk out", mdl[3][7:0], rdv);
    end
    $display("test modes done");
    // Random configuration readback and special bits
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      oscCrystal <= i[0];
      wr(pio_pkg::IDX_GEN_CFG, r);
      repeat (2) @(posedge ref_clk);
      rd(pio_pkg::IDX_GEN_CFG, rdv);
      chk("gen cfg", mdl[1][7:0] & 8'hFD, rdv & 8'hFD);
      chk("alt phase", {7'h0, r[6]}, {7'h0, altShiftPhase});
      chk("delay", {7'h0, r[7] & ~i[0]}, {7'h0, halt_startup_delay});
    end
    for (i = 0; i < 2; i++) begin
      oscillator_output <= i[0];
      repeat (3) @(posedge ref_clk);
      chk("osc pin", {i[0], 7'h0}, genPinOut & genPinOe & 8'h80);
    end
    wr(pio_pkg::IDX_GEN_CFG, 8'h00);
    for (i = 0; i < 2; i++) begin
      supervisor_error_out <= ~i[0];
      repeat (3) @(posedge ref_clk);
      chk("err oe", {6'h0, ~i[0], 1'b0}, genPinOe & 8'h02);
      chk("err out", 8'h00, genPinOut & genPinOe & 8'h02);
    end
    // Alternate function taps
    r = $random(seed);
    extAna <= r;
    extGenEn <= 8'hFF;
    extGenVal <= r;
    repeat (4) @(posedge ref_clk);
    rd(pio_pkg::IDX_ANA_PIN, rdv);
    chk("ana pin", r, rdv);
    chk("ana taps", {1'b0, r[7:1]}, {1'b0, comparator_output,
      comparatorChannels, current_source_output});
    chk("gen taps", {3'h0, r[6:5], r[3:2], r[0]}, {3'h0, serialDataIn,
      serial_shift_clock, timer_io_pin, timer_capture_pin,
      external_interrupt_pin});
    $display("test config done");
    // Events, status and mask
    oscCrystal <= 1'b0;
    extGenVal <= 8'h7F;
    extWkVal <= 4'h0;
    wr(pio_pkg::IDX_WK_EDGE, 8'h00);
    wr(pio_pkg::IDX_WK_CFG, 8'h00);
    repeat (4) @(posedge ref_clk);
    rd(pio_pkg::IDX_IRQ_STAT, rdv);
    m = wakeCnt;
    for (i = 0; i < 6; i++) begin
      wr(pio_pkg::IDX_IRQ_MASK, i[0] ? 8'hFF : 8'h00);
      if (i < 4) extWkVal[i] <= 1'b1;
      else if (i == 4) extGenVal[0] <= 1'b0;
      else extGenVal[7] <= 1'b1;
      repeat (5) @(posedge ref_clk);
      chk("irq mask", {7'h0, i[0]}, {7'h0, irq});
      rd(pio_pkg::IDX_IRQ_STAT, rdv);
      chk("status", 8'h01 << i, rdv);
      rd(pio_pkg::IDX_IRQ_STAT, rdv);
      chk("status clr", 8'h00, rdv);
      chk("irq clr", 8'h00, {7'h0, irq});
    end
    chk("wake pulses", 8'h04, 8'(wakeCnt - m));
    $display("test events done");
    // Idle then halt, each ended by an event
    wr(pio_pkg::IDX_GEN_OUT, 8'h40);
    waitMode(1'b0, 1'b1);
    extWkVal[0] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    extWkVal[0] <= 1'b1;
    waitMode(1'b0, 1'b0);
    // Halt without and then with the startup delay
    for (i = 0; i < 2; i++) begin
      wr(pio_pkg::IDX_GEN_CFG, {i[0], 7'h00});
      extGenVal[7] <= 1'b0;
      wr(pio_pkg::IDX_GEN_OUT, 8'h80);
      waitMode(1'b1, 1'b1);
      extGenVal[7] <= 1'b1;
      waitMode(1'b1, 1'b0);
      if (i == 0) m = n;
      else chk("startup", 8'h02, 8'(n - m));
    end
    rd(pio_pkg::IDX_GEN_OUT, rdv);
    chk("mode bits", 8'h00, rdv & 8'hC0);
    $display("test power done");
    testDone;
  end
endmodule
